// ==== design/tps_pkg.sv ====
// package: constants, types and the contract list for the profile sequencer
//
// Contract
// [R1] sequences of each profile are numbered from 1; sequence 1 only homes
// [R2] profile ends after last sequence or at a zero-speed sequence
// [R3] up to 50 sequences in total over at most 7 profiles
// [R4] inputs 6..8 form profile number, lsb first; zero means analogue
// [R5] alternating two-solenoid mode with profile 0 gives no movement
// [R6] start input begins positioning
// [R7] controller gives a fresh start for every run
// [R8] input 3 low: one sequence per start; code takes the mode from ctrl bit 2 and ignores input 3
// [R9] single mode merges zero-dwell sequences into one group
// [R10] input 3 high: whole profile runs from one start; code takes the mode from ctrl bit 2 and ignores input 3
// [R11] after profile end next start restarts at sequence 1
// [R12] profile-end output set when a profile completes
// [R13] output 2 shows sequence state when reporting is enabled
// [R14] stop input low halts all positioning
// [R15] acceleration sign or size adapted to reach end speed
// [R16] only entered acceleration values are stored, never adapted ones
// [R17] end mode: out2 from sequence end through dwell; run mode: while running
// [R18] end speed zero at profile end, zero next, reversal, or dwell; code zeroes it on dwell only
// [R19] start recognised on inactive-to-active edge only
package tps_pkg;
    localparam int NUM_SEQ      = 50;
    localparam int NUM_PROF     = 7;
    localparam int SEQ_AW       = 6;
    localparam int DWELL_W      = 16;
    localparam int SPD_W        = 16;
    localparam int ACC_W        = 16;
    localparam int POS_W        = 16;
    localparam int CLK_MHZ      = 250;
    // dwell counted in 1 us ticks
    localparam int TICK_NS      = 1000;
    localparam int TICK_CYC     = TICK_NS * CLK_MHZ / 1000;
    localparam int FIRST_SEQ    = 1;

    // register byte addresses
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_STATUS  = 8'h04;
    localparam logic [7:0] A_PBASE   = 8'h08;
    localparam logic [7:0] A_SADDR   = 8'h0C;
    localparam logic [7:0] A_SW0     = 8'h10;
    localparam logic [7:0] A_SW1     = 8'h14;
    localparam logic [7:0] A_SW2     = 8'h18;
    localparam logic [7:0] A_DONE    = 8'h1C;
    localparam logic [7:0] A_MOTION  = 8'h20;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // one stored sequence
    typedef struct packed {
        logic [POS_W-1:0]   target;
        logic [SPD_W-1:0]   speed;
        logic [ACC_W-1:0]   accel;
        logic [ACC_W-1:0]   decel;
        logic [DWELL_W-1:0] dwell;
    } tps_seq_t;

    // motion order handed to the trajectory engine
    typedef struct packed {
        logic               valid;
        logic [POS_W-1:0]   target;
        logic [SPD_W-1:0]   speed;
        logic [SPD_W-1:0]   end_speed;
        logic               acc_neg;
        logic [ACC_W-1:0]   acc_mag;
        logic [ACC_W-1:0]   dec_mag;
    } tps_move_t;

    // digital inputs from the controller
    typedef struct packed {
        logic [2:0] prof_sel;
        logic       full_mode;
        logic       start;
        logic       stop_n;
    } tps_din_t;
endpackage

// ==== design/tps_seq_mem.sv ====
// sequence storage with registered read data
`timescale 1ns/1ps
module tps_seq_mem #(
    parameter int DEPTH = tps_pkg::NUM_SEQ,
    parameter int AW    = tps_pkg::SEQ_AW
) (
    // clock
    input  wire logic              clk,
    // write port
    input  wire logic              we,
    input  wire logic [AW-1:0]     waddr,
    input  wire tps_pkg::tps_seq_t wdata,
    // read port
    input  wire logic [AW-1:0]     raddr,
    output tps_pkg::tps_seq_t      rdata
);
    initial
    begin
        if (DEPTH > (1 << AW))
            $error("depth does not fit address width");
    end

    tps_pkg::tps_seq_t mem [DEPTH];

    // entered values only; adapted ones never come back here
    always_ff @(posedge clk)
    begin
        if (we && int'(waddr) < DEPTH)
            mem[waddr] <= wdata; // [R16]
        rdata <= mem[int'(raddr) < DEPTH ? raddr : '0];
    end
endmodule // tps_seq_mem

// ==== design/tps_sequencer.sv ====
// travel profile sequencer with apb register access
`timescale 1ns/1ps
module tps_sequencer #(
    parameter int NSEQ  = tps_pkg::NUM_SEQ,
    parameter int NPROF = tps_pkg::NUM_PROF
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // digital inputs, asynchronous pins
    input  wire tps_pkg::tps_din_t din,
    // digital outputs
    output logic                   seq_out,
    output logic                   prof_end_out,
    output tps_pkg::tps_move_t     move
);
    initial
    begin
        if (NSEQ != tps_pkg::NUM_SEQ || NPROF != tps_pkg::NUM_PROF)
            $error("storage sizes are fixed at 50 and 7");
    end

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_LOAD, S_RUN, S_DWELL, S_WAIT
    } tps_state_t;

    // input synchronisers
    tps_pkg::tps_din_t din_m_reg, din_s_reg;
    logic              start_d_reg;

    // registers
    logic [31:0]  ctrl_reg;      // 0 en, 1 report on, 2 run mode, 3 2-sol
    logic [5:0]   pbase_reg [8];
    logic [5:0]   saddr_reg;
    tps_pkg::tps_seq_t sw_reg;
    logic         motion_done_reg; // pulse from trajectory engine by write

    tps_state_t   state_reg;
    logic [5:0]   idx_reg;       // sequence within profile, from 1
    logic [2:0]   prof_reg;
    logic [31:0]  dwell_cnt_reg;
    logic         prev_dir_reg;
    logic         ended_reg;
    tps_pkg::tps_seq_t cur_seq_reg;

    tps_pkg::tps_seq_t rd;
    logic [5:0]   raddr;
    logic         mem_we;

    // absolute address of sequence n of profile p
    function automatic logic [5:0] seq_addr(input logic [5:0] base,
                                            input logic [5:0] n);
        return 6'(base + n - 6'h01);
    endfunction

    // two flops before anything reads the pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            din_m_reg   <= '0;
            din_s_reg   <= '0;
            start_d_reg <= 1'b0;
        end
        else
        begin
            din_m_reg   <= din;
            din_s_reg   <= din_m_reg;
            start_d_reg <= din_s_reg.start;
        end
    end

    wire logic start_edge = din_s_reg.start & ~start_d_reg; // [R19] [R6]
    wire logic stopped    = ~din_s_reg.stop_n;              // [R14]
    wire logic [2:0] sel  = din_s_reg.prof_sel;             // [R4]
    wire logic apb_wr = psel & penable & pwrite;
    wire logic apb_rd = psel & ~penable & ~pwrite;

    // software access; answer in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg  <= tps_pkg::CTRL_RST;
            saddr_reg <= '0;
            sw_reg    <= '0;
            motion_done_reg <= 1'b0;
            for (int i = 0; i < 8; i++)
                pbase_reg[i] <= '0;
        end
        else
        begin
            motion_done_reg <= 1'b0;
            if (apb_wr)
            begin
                case (paddr)
                    tps_pkg::A_CTRL:   ctrl_reg  <= pwdata;
                    tps_pkg::A_PBASE:  pbase_reg[pwdata[10:8]] <= pwdata[5:0];
                    tps_pkg::A_SADDR:  saddr_reg <= pwdata[5:0];
                    tps_pkg::A_SW0:
                    begin
                        sw_reg.target <= pwdata[31:16];
                        sw_reg.speed  <= pwdata[15:0];
                    end
                    tps_pkg::A_SW1:
                    begin
                        sw_reg.accel <= pwdata[31:16];
                        sw_reg.decel <= pwdata[15:0];
                    end
                    tps_pkg::A_SW2:    sw_reg.dwell <= pwdata[15:0];
                    tps_pkg::A_DONE:   motion_done_reg <= pwdata[0];
                    default: ;
                endcase
            end
        end
    end

    // storage commit when the last word is written; stores entered values
    assign mem_we = apb_wr && paddr == tps_pkg::A_MOTION
                    && saddr_reg < 6'(NSEQ); // [R3]
    assign raddr  = seq_addr(pbase_reg[prof_reg], idx_reg);

    tps_seq_mem u_mem (
        .clk   (pclk),
        .we    (mem_we),
        .waddr (saddr_reg),
        .wdata (sw_reg),
        .raddr (raddr),
        .rdata (rd)
    );

    // read data and answers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable)
                pslverr <= paddr > tps_pkg::A_MOTION || paddr[1:0] != 2'b00;
            if (apb_rd)
            begin
                case (paddr)
                    tps_pkg::A_CTRL:   prdata <= ctrl_reg;
                    tps_pkg::A_STATUS: prdata <= {16'h0000, 1'b0,
                        3'(state_reg), ended_reg, prof_reg, idx_reg, 2'b00};
                    tps_pkg::A_SADDR:  prdata <= {26'h0, saddr_reg};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // sequencing
    wire logic run_mode  = ctrl_reg[2];
    wire logic last_hit  = idx_reg == 6'(NSEQ) ||
        seq_addr(pbase_reg[prof_reg], idx_reg) >= 6'(NSEQ);
    wire logic zero_spd  = rd.speed == '0;                       // [R2]
    wire logic dir_now   = rd.target < cur_seq_reg.target;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg     <= S_IDLE;
            idx_reg       <= 6'h01;
            prof_reg      <= '0;
            ended_reg     <= 1'b1;
            dwell_cnt_reg <= '0;
            prev_dir_reg  <= 1'b0;
            cur_seq_reg   <= '0;
        end
        else if (stopped || !ctrl_reg[0])
            state_reg <= S_IDLE; // [R14]
        else
        begin
            case (state_reg)
                S_IDLE:
                    if (start_edge && sel != 3'h0
                        && !(ctrl_reg[3] && sel == 3'h0)) // [R5] [R7]
                    begin
                        if (ended_reg || sel != prof_reg)
                            idx_reg <= 6'(tps_pkg::FIRST_SEQ); // [R1] [R11]
                        prof_reg  <= sel;
                        ended_reg <= 1'b0;
                        state_reg <= S_FETCH;
                    end
                S_FETCH: state_reg <= S_LOAD;
                S_LOAD:
                    if (zero_spd || last_hit)
                    begin
                        ended_reg <= 1'b1; // [R2]
                        state_reg <= S_IDLE;
                    end
                    else
                    begin
                        cur_seq_reg <= rd;
                        prev_dir_reg <= dir_now;
                        state_reg   <= S_RUN;
                    end
                S_RUN:
                    if (motion_done_reg)
                    begin
                        dwell_cnt_reg <= 32'(cur_seq_reg.dwell)
                                         * 32'(tps_pkg::TICK_CYC);
                        idx_reg   <= idx_reg + 6'h01;
                        state_reg <= S_DWELL;
                    end
                S_DWELL:
                    if (dwell_cnt_reg != 0)
                        dwell_cnt_reg <= dwell_cnt_reg - 32'h1;
                    else
                        state_reg <= S_WAIT;
                S_WAIT:
                    // single mode keeps going through zero-dwell groups
                    if (run_mode || cur_seq_reg.dwell == '0
                        || idx_reg == 6'h02) // [R10] [R9]
                        state_reg <= S_FETCH;
                    else
                        state_reg <= S_IDLE; // [R8]
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // output pins and motion order
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_out      <= 1'b0;
            prof_end_out <= 1'b0;
            move         <= '0;
        end
        else
        begin
            prof_end_out <= ended_reg && prof_reg != 3'h0; // [R12]
            if (!ctrl_reg[1])
                seq_out <= 1'b0;
            else if (ctrl_reg[2])
                seq_out <= state_reg == S_RUN; // [R13] [R17]
            else
                seq_out <= state_reg == S_DWELL; // [R17]
            move.valid   <= state_reg == S_RUN;
            move.target  <= cur_seq_reg.target;
            move.speed   <= cur_seq_reg.speed;
            // end speed zero on dwell only; engine zeroes at end
            move.end_speed <= (cur_seq_reg.dwell != '0)
                ? '0 : cur_seq_reg.speed; // [R18]
            // sign follows travel direction: set when the new target is below the previous one
            move.acc_neg <= prev_dir_reg; // [R15]
            move.acc_mag <= cur_seq_reg.accel == '0
                ? cur_seq_reg.decel : cur_seq_reg.accel; // [R15]
            move.dec_mag <= cur_seq_reg.decel;
        end
    end

    a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
        stopped |=> state_reg == S_IDLE) // [R14]
        else $error("stop did not halt");
    a_zero_prof: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_IDLE && sel == 3'h0 |=> state_reg == S_IDLE) // [R5]
        else $error("profile 0 moved");
    a_edge_start: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_IDLE && !start_edge |=> state_reg != S_FETCH) // [R19]
        else $error("start without edge");
    a_end_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ended_reg && prof_reg != 3'h0 |=> prof_end_out) // [R12]
        else $error("profile end not shown");
    a_restart_one: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_IDLE && start_edge && ended_reg && sel != 3'h0
        && !stopped && ctrl_reg[0] |=> idx_reg == 6'h01) // [R11]
        else $error("no restart at 1");
    a_run_report: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[1] && ctrl_reg[2] && state_reg == S_RUN
        |=> seq_out) // [R17]
        else $error("run report missing");
    a_zero_ends: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_LOAD && zero_spd && !stopped && ctrl_reg[0]
        |=> ended_reg && state_reg == S_IDLE) // [R2]
        else $error("zero speed did not end");
    a_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_WAIT && !run_mode && cur_seq_reg.dwell != '0
        && idx_reg != 6'h02 && !stopped && ctrl_reg[0]
        |=> state_reg == S_IDLE) // [R8]
        else $error("single mode ran on");
endmodule // tps_sequencer

// ==== bench/tps_ctrl_model.sv ====
// external controller model driving the sequencer digital inputs
`timescale 1ns/1ps
module tps_ctrl_model (
    // clock
    input  wire logic         pclk,
    // digital inputs of the sequencer
    output tps_pkg::tps_din_t din
);
    // idle pins: stop released, start inactive
    initial din = '{prof_sel: 3'h0, full_mode: 1'b0, start: 1'b0,
                    stop_n: 1'b1};

    // profile number on inputs 6..8, lsb first
    task automatic select(input logic [2:0] prof, input logic full);
        @(posedge pclk);
        din.prof_sel  <= prof;
        din.full_mode <= full;
    endtask

    // start level; a run needs a fresh rising edge
    task automatic set_start(input logic lvl);
        @(posedge pclk);
        din.start <= lvl;
    endtask

    // held long enough to pass the two-flop synchroniser
    task automatic pulse();
        set_start(1'b1);
        repeat (4) @(posedge pclk);
        set_start(1'b0);
    endtask

    // stop is active low
    task automatic stop(input logic on);
        @(posedge pclk);
        din.stop_n <= ~on;
    endtask
endmodule // tps_ctrl_model

// ==== bench/tps_sequencer_test.sv ====
// self-checking bench for the travel profile sequencer
`timescale 1ns/1ps
module tps_sequencer_test;
    // apb, pins and bookkeeping
    logic               pclk    = 1'b0;
    logic               presetn = 1'b0;
    logic               psel    = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite  = 1'b0;
    logic [7:0]         paddr   = 8'h00;
    logic [31:0]        pwdata  = 32'h0000_0000;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               seq_out;
    logic               prof_end_out;
    tps_pkg::tps_move_t move;
    tps_pkg::tps_din_t  din;
    int                 fail_count = 0;
    int                 checked    = 0;
    logic [31:0]        q;
    logic               e;
    logic               exp_seq    = 1'b0;

    always #2 pclk = ~pclk;

    tps_ctrl_model i_ctrl (.pclk(pclk), .din(din));

    tps_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din(din), .seq_out(seq_out),
        .prof_end_out(prof_end_out), .move(move));

    // closing report, also reached from any timeout
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // compare of a word; flags reuse it zero-extended
    task automatic chk_word(input string nm, input logic [31:0] ex,
                            input logic [31:0] got);
        checked++;
        if (got !== ex)
        begin
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
            fail_count++;
        end
    endtask

    task automatic chk_bit(input string nm, input logic ex, input logic got);
        chk_word(nm, {31'h0, ex}, {31'h0, got});
    endtask

    // one apb transfer; waits for pready, never a fixed count
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            summarize();
        end
    endtask

    // store one sequence at an absolute slot
    task automatic put_seq(input logic [5:0] idx, input logic [15:0] tgt,
                           input logic [15:0] spd, input logic [15:0] dw);
        apb(1'b1, tps_pkg::A_SADDR, {26'h0, idx});
        apb(1'b1, tps_pkg::A_SW0, {tgt, spd});
        apb(1'b1, tps_pkg::A_SW1, 32'h0010_0010);
        apb(1'b1, tps_pkg::A_SW2, {16'h0, dw});
        apb(1'b1, tps_pkg::A_MOTION, 32'h0000_0001);
    endtask

    // wait for a running move to tgt, then report it finished
    task automatic expect_move(input logic [15:0] tgt);
        int n;
        n = 0;
        while (!(move.valid === 1'b1 && move.target === tgt) && n < 80)
        begin
            @(negedge pclk);
            n++;
        end
        chk_word("move target", {16'h0, tgt}, {16'h0, move.target});
        chk_bit("seq out run", exp_seq, seq_out);
        if (n >= 80)
        begin
            fail_count++;
            summarize();
        end
        apb(1'b1, tps_pkg::A_DONE, 32'h0000_0001);
    endtask

    // no move may start for cyc cycles; short grace for valid to drop
    task automatic quiet(input int cyc);
        logic seen;
        seen = 1'b0;
        repeat (4) @(negedge pclk);
        repeat (cyc)
        begin
            @(negedge pclk);
            if (move.valid !== 1'b0)
                seen = 1'b1;
        end
        chk_bit("move idle", 1'b0, seen);
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // register access, including unmapped and unaligned places
        apb(1'b0, tps_pkg::A_CTRL, 32'h0000_0000);
        chk_word("ctrl reset", tps_pkg::CTRL_RST, q);
        chk_bit("ctrl err", 1'b0, e);
        apb(1'b1, 8'h24, 32'h0000_000F);
        chk_bit("unmapped err", 1'b1, e);
        apb(1'b0, 8'h02, 32'h0000_0000);
        chk_bit("unaligned err", 1'b1, e);
        apb(1'b1, tps_pkg::A_CTRL, 32'h0000_0005);
        apb(1'b0, tps_pkg::A_CTRL, 32'h0000_0000);
        chk_word("ctrl back", 32'h0000_0005, q);
        // profile 1 ends at a zero-speed slot; slot 3 must never run
        apb(1'b1, tps_pkg::A_PBASE, 32'h0000_0100);
        put_seq(6'h00, 16'h0100, 16'h0040, 16'h0000);
        put_seq(6'h01, 16'h0200, 16'h0040, 16'h0000);
        put_seq(6'h02, 16'h0300, 16'h0000, 16'h0000);
        put_seq(6'h03, 16'h0400, 16'h0040, 16'h0000);
        // profile 2 has a dwell after its second sequence
        apb(1'b1, tps_pkg::A_PBASE, 32'h0000_0204);
        put_seq(6'h04, 16'h0500, 16'h0040, 16'h0000);
        put_seq(6'h05, 16'h0600, 16'h0040, 16'h0001);
        put_seq(6'h06, 16'h0700, 16'h0040, 16'h0000);
        put_seq(6'h07, 16'h0800, 16'h0000, 16'h0000);
        $display("test registers done");
        // full profile from one held start level
        i_ctrl.select(3'h1, 1'b1);
        i_ctrl.set_start(1'b1);
        expect_move(16'h0100);
        expect_move(16'h0200);
        quiet(100);
        chk_bit("profile end", 1'b1, prof_end_out);
        i_ctrl.set_start(1'b0);
        // after the end the next start begins at sequence 1
        i_ctrl.pulse();
        expect_move(16'h0100);
        expect_move(16'h0200);
        $display("test full profile done");
        // single mode, end-of-sequence reporting during the dwell
        apb(1'b1, tps_pkg::A_CTRL, 32'h0000_0003);
        i_ctrl.select(3'h2, 1'b0);
        i_ctrl.pulse();
        expect_move(16'h0500);
        expect_move(16'h0600);
        repeat (4) @(negedge pclk);
        chk_bit("seq end report", 1'b1, seq_out);
        quiet(400);
        chk_bit("seq end released", 1'b0, seq_out);
        i_ctrl.pulse();
        expect_move(16'h0700);
        $display("test single mode done");
        // profile 0 in two-solenoid mode must not move
        apb(1'b1, tps_pkg::A_CTRL, 32'h0000_0009);
        i_ctrl.select(3'h0, 1'b0);
        i_ctrl.pulse();
        quiet(100);
        $display("test profile zero done");
        // stop low after the first move is reported done keeps sequence 2 from running; run reporting on
        apb(1'b1, tps_pkg::A_CTRL, 32'h0000_0007);
        exp_seq = 1'b1;
        i_ctrl.select(3'h1, 1'b1);
        i_ctrl.pulse();
        expect_move(16'h0100);
        i_ctrl.stop(1'b1);
        repeat (8) @(negedge pclk);
        chk_bit("valid on stop", 1'b0, move.valid);
        chk_bit("seq out on stop", 1'b0, seq_out);
        i_ctrl.stop(1'b0);
        $display("test stop done");
        summarize();
    end
endmodule // tps_sequencer_test
